// ### rtl/cpu_core_register_set.sv
// Programmer-visible register set of the 8-bit core: data registers, PC, flags, stack.
`timescale 1ns/1ps
// Overview of operation
// RULE1: Eight-bit accumulator sum_reg, read and written in data space at FFh.
// RULE2: pointer_one and pointer_two sit in data space at 80h and 81h.
// RULE3: short_direct_first and short_direct_one sit in data space at 82h and 83h.
// RULE4: Pointers drive indirect addressing and are also plain data-space registers.
// RULE5: Twelve-bit program counter holds the next fetch address, reaching 4096 bytes.
// RULE6: A program bank register extends fetch addressing beyond 4096 bytes.
// RULE7: PC increments after each fetch; relative jumps add the offset.
// RULE8: PC loads jump/call target, relative sum, vectors, popped address, or PC+1.
// RULE9: Three carry/zero pairs: main, interrupt and urgent contexts.
// RULE10: Interrupts switch to their pair; irq_exit_op restores the previous pair (from the interrupt pair the code always returns to main).
// RULE11: Only the active pair is touched; switching never clears any pair.
// RULE12: Active carry takes arithmetic carry/borrow, tested bit, or rotate result.
// RULE13: Active zero is set when the latest result is zero, else cleared.
// RULE14: Reset starts in the urgent context with the urgent pair active.
// RULE15: Six-level twelve-bit return stack, no stack pointer, outside data RAM.
// RULE16: Call or interrupt shifts levels up and stores the PC in level one.
// RULE17: Returns load level one into the PC and shift levels down.
// RULE18: Only the PC is stacked; data registers are never saved.
// RULE19: Beyond six nested entries the stack stays deepest, losing the oldest.
// RULE20: Return on an empty stack leaves it and runs the next instruction.
module cpu_core_register_set (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [7:0] ds_addr_i,
  input wire logic ds_we_i,
  input wire logic ds_re_i,
  input wire logic [7:0] ds_wdata_i,
  input wire logic [9:0] pc_op_i,
  input wire logic [11:0] pc_target_i,
  input wire logic [7:0] rel_offset_i,
  input wire logic rel_sub_i,
  input wire logic [11:0] vector_i,
  input wire logic bank_we_i,
  input wire logic [1:0] bank_wdata_i,
  input wire logic carry_we_i,
  input wire logic carry_i,
  input wire logic zero_we_i,
  input wire logic [7:0] result_i,
  output logic [7:0] ds_rdata_o,
  output logic ds_hit_o,
  output logic [7:0] sum_o,
  output logic [7:0] pointer_one_o,
  output logic [7:0] pointer_two_o,
  output logic [7:0] short_direct_first_o,
  output logic [7:0] short_direct_one_o,
  output logic [11:0] pc_o,
  output logic [13:0] fetch_addr_o,
  output logic carry_o,
  output logic zero_o,
  output logic [2:0] ctx_o,
  output logic [2:0] stack_depth_o
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic [7:0] sum;
    logic [7:0] ptr_one;
    logic [7:0] ptr_two;
    logic [7:0] sd_first;
    logic [7:0] sd_one;
    logic [11:0] pc;
    logic [1:0] bank;
    core_regs_pkg::ctx_t ctx;
    core_regs_pkg::ctx_t urgent_prev;
    logic [2:0] carry;
    logic [2:0] zero;
    logic [7:0] rdata;
    logic hit;
  } core_state_t;

  core_state_t s_r;
  core_state_t s_nxt;

  logic stk_push;
  logic stk_pop;
  logic [11:0] stk_top;
  logic stk_empty;
  logic stk_full;
  logic [2:0] stk_depth;
  logic [11:0] pc_plus1;
  logic [11:0] pc_rel;
  logic [11:0] rel_ext;
  core_regs_pkg::pc_op_t op;

  // Picks the bit of the pair that belongs to the given context.
  function automatic logic pick_flag(input logic [2:0] bits, input core_regs_pkg::ctx_t c);
    pick_flag = |(bits & c);
  endfunction : pick_flag

  // Replaces only the bit of the given context, leaving the other pairs alone.
  function automatic logic [2:0] put_flag(input logic [2:0] bits, input core_regs_pkg::ctx_t c,
      input logic v);
    put_flag = (bits & ~c) | (c & {3{v}});
  endfunction : put_flag

  // Decodes whether a data-space address hits a core register.
  function automatic logic is_mapped(input logic [7:0] a);
    is_mapped = (a == core_regs_pkg::ADDR_SUM) || (a == core_regs_pkg::ADDR_POINTER_ONE) ||
        (a == core_regs_pkg::ADDR_POINTER_TWO) || (a == core_regs_pkg::ADDR_SHORT_FIRST) ||
        (a == core_regs_pkg::ADDR_SHORT_ONE);
  endfunction : is_mapped

  assign op = core_regs_pkg::pc_op_t'(pc_op_i);
  assign pc_plus1 = 12'(s_r.pc + core_regs_pkg::PC_STEP); // RULE7
  assign rel_ext = {4'h0, rel_offset_i};
  assign pc_rel = rel_sub_i ? 12'(s_r.pc - rel_ext) : 12'(s_r.pc + rel_ext); // RULE7

  // Only the program counter enters the stack, never a data register.
  assign stk_push = (op == core_regs_pkg::PC_CALL) || (op == core_regs_pkg::PC_IRQ) ||
      (op == core_regs_pkg::PC_URGENT); // RULE18
  assign stk_pop = (op == core_regs_pkg::PC_RET) || (op == core_regs_pkg::PC_IRQ_EXIT_OP);

  // ****************************************************************
  // Return stack
  // ****************************************************************
  return_stack u_stack ( // RULE15
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .push_i(stk_push),
    .pop_i(stk_pop),
    .push_addr_i(s_r.pc),
    .top_o(stk_top),
    .empty_o(stk_empty),
    .full_o(stk_full),
    .depth_o(stk_depth)
  );

  // ****************************************************************
  // Next-state logic
  // ****************************************************************
  always_comb begin
    s_nxt = s_r;
    if (!rst_n_i) begin
      s_nxt.sum = core_regs_pkg::RESET_DATA;
      s_nxt.ptr_one = core_regs_pkg::RESET_DATA;
      s_nxt.ptr_two = core_regs_pkg::RESET_DATA;
      s_nxt.sd_first = core_regs_pkg::RESET_DATA;
      s_nxt.sd_one = core_regs_pkg::RESET_DATA;
      s_nxt.pc = core_regs_pkg::RESET_PC;
      s_nxt.bank = core_regs_pkg::RESET_BANK;
      s_nxt.ctx = core_regs_pkg::CTX_URGENT; // RULE14
      s_nxt.urgent_prev = core_regs_pkg::CTX_MAIN;
      s_nxt.carry = 3'h0;
      s_nxt.zero = 3'h0;
      s_nxt.rdata = core_regs_pkg::RESET_DATA;
      s_nxt.hit = 1'b0;
    end else begin
      // Data-space writes to the mapped registers.
      if (ds_we_i) begin
        unique case (ds_addr_i)
          core_regs_pkg::ADDR_SUM: s_nxt.sum = ds_wdata_i; // RULE1
          core_regs_pkg::ADDR_POINTER_ONE: s_nxt.ptr_one = ds_wdata_i; // RULE2
          core_regs_pkg::ADDR_POINTER_TWO: s_nxt.ptr_two = ds_wdata_i; // RULE2
          core_regs_pkg::ADDR_SHORT_FIRST: s_nxt.sd_first = ds_wdata_i; // RULE3
          core_regs_pkg::ADDR_SHORT_ONE: s_nxt.sd_one = ds_wdata_i; // RULE3
          default: s_nxt.sum = s_r.sum;
        endcase
      end
      // Registered read answer; unmapped addresses answer zero with no hit.
      if (ds_re_i) begin
        s_nxt.hit = is_mapped(ds_addr_i);
        unique case (ds_addr_i)
          core_regs_pkg::ADDR_SUM: s_nxt.rdata = s_r.sum; // RULE1
          core_regs_pkg::ADDR_POINTER_ONE: s_nxt.rdata = s_r.ptr_one; // RULE4
          core_regs_pkg::ADDR_POINTER_TWO: s_nxt.rdata = s_r.ptr_two; // RULE4
          core_regs_pkg::ADDR_SHORT_FIRST: s_nxt.rdata = s_r.sd_first; // RULE3
          core_regs_pkg::ADDR_SHORT_ONE: s_nxt.rdata = s_r.sd_one; // RULE3
          default: s_nxt.rdata = core_regs_pkg::UNMAPPED_DATA;
        endcase
      end else begin
        s_nxt.hit = 1'b0;
      end

      // Program bank extends fetches past the counter's own reach.
      if (bank_we_i) begin
        s_nxt.bank = bank_wdata_i; // RULE6
      end

      // Flag updates land in the pair of the context active this cycle,
      // so an instruction finishing as an interrupt arrives keeps its own pair.
      if (carry_we_i) begin
        s_nxt.carry = put_flag(s_r.carry, s_r.ctx, carry_i); // RULE12 RULE11
      end
      if (zero_we_i) begin
        s_nxt.zero = put_flag(s_r.zero, s_r.ctx, result_i == 8'h00); // RULE13 RULE11
      end

      // Program counter sources and context switching.
      unique case (op)
        core_regs_pkg::PC_HOLD: s_nxt.pc = s_r.pc;
        core_regs_pkg::PC_NEXT: s_nxt.pc = pc_plus1; // RULE7 RULE8
        core_regs_pkg::PC_JUMP: s_nxt.pc = pc_target_i; // RULE8
        core_regs_pkg::PC_CALL: s_nxt.pc = pc_target_i; // RULE8
        core_regs_pkg::PC_REL: s_nxt.pc = pc_rel; // RULE8
        core_regs_pkg::PC_RESETV: s_nxt.pc = vector_i; // RULE8
        core_regs_pkg::PC_IRQ: begin
          s_nxt.pc = vector_i; // RULE8
          s_nxt.ctx = core_regs_pkg::CTX_IRQ; // RULE10 RULE9
        end
        core_regs_pkg::PC_URGENT: begin
          s_nxt.pc = vector_i; // RULE8
          // A repeated urgent entry must not overwrite the context to return to.
          if (s_r.ctx != core_regs_pkg::CTX_URGENT) begin
            s_nxt.urgent_prev = s_r.ctx; // RULE10
          end
          s_nxt.ctx = core_regs_pkg::CTX_URGENT; // RULE10 RULE9
        end
        core_regs_pkg::PC_RET: begin
          s_nxt.pc = stk_empty ? pc_plus1 : stk_top; // RULE17 RULE20
        end
        core_regs_pkg::PC_IRQ_EXIT_OP: begin
          s_nxt.pc = stk_empty ? pc_plus1 : stk_top; // RULE17 RULE20
          if (s_r.ctx == core_regs_pkg::CTX_URGENT) begin
            s_nxt.ctx = s_r.urgent_prev; // RULE10
          end else begin
            s_nxt.ctx = core_regs_pkg::CTX_MAIN; // RULE10
          end
        end
        default: s_nxt.pc = s_r.pc;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    s_r <= s_nxt;
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign ds_rdata_o = s_r.rdata;
  assign ds_hit_o = s_r.hit;
  assign sum_o = s_r.sum;
  assign pointer_one_o = s_r.ptr_one; // RULE4
  assign pointer_two_o = s_r.ptr_two; // RULE4
  assign short_direct_first_o = s_r.sd_first;
  assign short_direct_one_o = s_r.sd_one;
  assign pc_o = s_r.pc; // RULE5
  assign fetch_addr_o = {s_r.bank, s_r.pc}; // RULE6
  assign carry_o = pick_flag(s_r.carry, s_r.ctx); // RULE9
  assign zero_o = pick_flag(s_r.zero, s_r.ctx); // RULE9
  assign ctx_o = s_r.ctx;
  assign stack_depth_o = stk_depth;

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  sequence irq_entry_s;
    op == core_regs_pkg::PC_IRQ && s_r.ctx == core_regs_pkg::CTX_MAIN;
  endsequence

  sequence irq_return_s;
    op == core_regs_pkg::PC_IRQ_EXIT_OP && s_r.ctx == core_regs_pkg::CTX_IRQ;
  endsequence

  sum_write_a: assert property ((ds_we_i && ds_addr_i == 8'hFF) |=>
      sum_o == $past(ds_wdata_i)) // RULE1
    else $error("Accumulator did not take the data-space write.");
  pointer_map_a: assert property ((ds_we_i && ds_addr_i == 8'h81) |=>
      pointer_two_o == $past(ds_wdata_i) && $stable(pointer_one_o)) // RULE2
    else $error("Second pointer write went to the wrong register.");
  short_read_a: assert property ((ds_re_i && !ds_we_i && ds_addr_i == 8'h83) |=>
      ds_hit_o && ds_rdata_o == short_direct_one_o) // RULE3
    else $error("Short-direct read returned wrong data.");
  pointer_read_a: assert property ((ds_re_i && !ds_we_i && ds_addr_i == 8'h80) |=>
      ds_rdata_o == pointer_one_o) // RULE4
    else $error("First pointer read returned wrong data.");
  pc_next_a: assert property (op == core_regs_pkg::PC_NEXT |=>
      pc_o == 12'($past(pc_o) + 12'h001)) // RULE7
    else $error("Program counter did not advance by one.");
  pc_call_a: assert property (op == core_regs_pkg::PC_CALL |=>
      pc_o == $past(pc_target_i) && stack_depth_o != 3'h0) // RULE8
    else $error("Call did not load the target and stack the return.");
  irq_switch_a: assert property (irq_entry_s ##[1:4] irq_return_s |=>
      ctx_o == core_regs_pkg::CTX_MAIN) // RULE10
    else $error("Interrupt return did not restore the main pair.");
  flag_keep_a: assert property ((s_r.ctx == core_regs_pkg::CTX_MAIN) |=>
      s_r.carry[2:1] == $past(s_r.carry[2:1])) // RULE11
    else $error("An inactive carry flag changed.");
  zero_set_a: assert property ((zero_we_i && result_i == 8'h00 && op == core_regs_pkg::PC_HOLD)
      |=> zero_o) // RULE13
    else $error("Zero flag not set for a zero result.");
  ret_empty_a: assert property ((stk_pop && stk_empty) |=>
      pc_o == 12'($past(pc_o) + 12'h001)) // RULE20
    else $error("Return on empty stack did not continue in sequence.");
  reset_ctx_a: assert property (@(posedge clk_i) $rose(rst_n_i) |->
      ctx_o == core_regs_pkg::CTX_URGENT) // RULE14
    else $error("Reset did not select the urgent context.");

  sequence urgent_entry_s;
    op == core_regs_pkg::PC_URGENT && s_r.ctx != core_regs_pkg::CTX_URGENT;
  endsequence

  stack_full_a: assert property ((stk_push && stk_full) |=> // RULE19
      stack_depth_o == core_regs_pkg::STACK_FULL)
    else $error("Push on a full stack changed its depth.");
  push_depth_a: assert property ((stk_push && !stk_full) |=> // RULE16
      stack_depth_o == 3'($past(stack_depth_o) + 3'h1))
    else $error("Push did not deepen the stack by one.");
  ret_pop_a: assert property ((stk_pop && !stk_empty) |=> // RULE17
      pc_o == $past(stk_top))
    else $error("Return did not load the first stack level.");
  data_keep_a: assert property ((stk_push && !ds_we_i) |=> // RULE18
      $stable(sum_o) && $stable(pointer_one_o))
    else $error("A call or interrupt changed a data register.");
  fetch_bank_a: assert property (bank_we_i |=> // RULE6
      fetch_addr_o[13:12] == $past(bank_wdata_i))
    else $error("Program bank write did not reach the fetch address.");
  pc_jump_a: assert property (op == core_regs_pkg::PC_JUMP |=> // RULE8
      pc_o == $past(pc_target_i) && $stable(stack_depth_o))
    else $error("Jump did not load the target alone.");
  rel_add_a: assert property ((op == core_regs_pkg::PC_REL && !rel_sub_i) |=> // RULE7
      pc_o == 12'($past(pc_o) + 12'($past(rel_offset_i))))
    else $error("Forward relative branch gave a wrong counter.");
  rel_sub_a: assert property ((op == core_regs_pkg::PC_REL && rel_sub_i) |=> // RULE8
      pc_o == 12'($past(pc_o) - 12'($past(rel_offset_i))))
    else $error("Backward relative branch gave a wrong counter.");
  vector_load_a: assert property ((op == core_regs_pkg::PC_IRQ || // RULE8
      op == core_regs_pkg::PC_URGENT || op == core_regs_pkg::PC_RESETV) |=>
      pc_o == $past(vector_i))
    else $error("Vector was not loaded into the counter.");
  irq_ctx_a: assert property (op == core_regs_pkg::PC_IRQ |=> // RULE9
      ctx_o == core_regs_pkg::CTX_IRQ)
    else $error("Interrupt entry did not select the interrupt pair.");
  urgent_save_a: assert property (urgent_entry_s |=> // RULE10
      ctx_o == core_regs_pkg::CTX_URGENT && s_r.urgent_prev == $past(s_r.ctx))
    else $error("Urgent entry did not save the context to return to.");
  urgent_exit_a: assert property ((op == core_regs_pkg::PC_IRQ_EXIT_OP && // RULE10
      s_r.ctx == core_regs_pkg::CTX_URGENT) |=> ctx_o == $past(s_r.urgent_prev))
    else $error("Return from urgent service did not restore the saved pair.");
  carry_load_a: assert property ((carry_we_i && op == core_regs_pkg::PC_HOLD) |=> // RULE12
      carry_o == $past(carry_i))
    else $error("Carry flag did not take the new value.");
  zero_clear_a: assert property ((zero_we_i && result_i != 8'h00 && // RULE13
      op == core_regs_pkg::PC_HOLD) |=> !zero_o)
    else $error("Zero flag not cleared for a nonzero result.");

endmodule : cpu_core_register_set

// ### rtl/core_regs_pkg.sv
// Shared constants and types of the programmer-visible core register set.
package core_regs_pkg;

  // ****************************************************************
  // Data-space addresses of the mapped core registers
  // ****************************************************************
  localparam logic [7:0] ADDR_POINTER_ONE = 8'h80;
  localparam logic [7:0] ADDR_POINTER_TWO = 8'h81;
  localparam logic [7:0] ADDR_SHORT_FIRST = 8'h82;
  localparam logic [7:0] ADDR_SHORT_ONE = 8'h83;
  localparam logic [7:0] ADDR_SUM = 8'hFF;

  // ****************************************************************
  // Widths, depths and reset values
  // ****************************************************************
  localparam int DATA_W = 8;
  localparam int PC_W = 12;
  localparam int BANK_W = 2;
  localparam int STACK_LEVELS = 6;
  localparam int DEPTH_W = 3;
  localparam logic [DEPTH_W-1:0] STACK_FULL = 3'h6;
  localparam logic [7:0] RESET_DATA = 8'h00;
  localparam logic [7:0] UNMAPPED_DATA = 8'h00;
  localparam logic [11:0] RESET_PC = 12'h000;
  localparam logic [11:0] PC_STEP = 12'h001;
  localparam logic [1:0] RESET_BANK = 2'h0;

  // ****************************************************************
  // Flag contexts, one-hot so a code doubles as a mask of the pair
  // ****************************************************************
  typedef enum logic [2:0] {
    CTX_MAIN = 3'b001,
    CTX_IRQ = 3'b010,
    CTX_URGENT = 3'b100
  } ctx_t;

  // ****************************************************************
  // Program counter update sources
  // ****************************************************************
  typedef enum logic [9:0] {
    PC_HOLD = 10'h001,
    PC_NEXT = 10'h002,
    PC_JUMP = 10'h004,
    PC_CALL = 10'h008,
    PC_REL = 10'h010,
    PC_IRQ = 10'h020,
    PC_URGENT = 10'h040,
    PC_RESETV = 10'h080,
    PC_RET = 10'h100,
    PC_IRQ_EXIT_OP = 10'h200
  } pc_op_t;

endpackage : core_regs_pkg

// ### rtl/return_stack.sv
// Six-level hardware return stack without a stack pointer.
`timescale 1ns/1ps
module return_stack (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic push_i,
  input wire logic pop_i,
  input wire logic [11:0] push_addr_i,
  output logic [11:0] top_o,
  output logic empty_o,
  output logic full_o,
  output logic [2:0] depth_o
);

  typedef struct packed {
    logic [core_regs_pkg::STACK_LEVELS-1:0][core_regs_pkg::PC_W-1:0] lvl;
    logic [core_regs_pkg::DEPTH_W-1:0] depth;
  } stack_state_t;

  stack_state_t s_r;
  stack_state_t s_nxt;

  // ****************************************************************
  // Shift register levels
  // ****************************************************************
  always_comb begin
    s_nxt = s_r;
    if (!rst_n_i) begin
      s_nxt = '0;
    end else if (push_i) begin
      for (int i = core_regs_pkg::STACK_LEVELS - 1; i > 0; i--) begin
        s_nxt.lvl[i] = s_r.lvl[i-1]; // RULE16
      end
      s_nxt.lvl[0] = push_addr_i; // RULE16
      // The oldest level falls off the end; the count just saturates.
      if (s_r.depth != core_regs_pkg::STACK_FULL) begin
        s_nxt.depth = 3'(s_r.depth + 3'h1); // RULE19
      end
    end else if (pop_i && (s_r.depth != 3'h0)) begin
      for (int i = 0; i < core_regs_pkg::STACK_LEVELS - 1; i++) begin
        s_nxt.lvl[i] = s_r.lvl[i+1]; // RULE17
      end
      s_nxt.depth = 3'(s_r.depth - 3'h1); // RULE17
    end
  end

  always_ff @(posedge clk_i) begin
    s_r <= s_nxt;
  end

  assign top_o = s_r.lvl[0];
  assign empty_o = (s_r.depth == 3'h0); // RULE20
  assign full_o = (s_r.depth == core_regs_pkg::STACK_FULL);
  assign depth_o = s_r.depth;

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  push_top_a: assert property (push_i |=> top_o == $past(push_addr_i)) // RULE16
    else $error("Pushed address is not on the first level.");
  pop_shift_a: assert property ((pop_i && !push_i && !empty_o) |=> // RULE17
      depth_o == 3'($past(depth_o) - 3'h1))
    else $error("Pop did not lower the stack depth by one.");
  pop_second_a: assert property ((pop_i && !push_i && depth_o > 3'h1) |=>
      top_o == $past(s_r.lvl[1])) // RULE17
    else $error("Second level did not move to the first on pop.");
  deep_sat_a: assert property ((push_i && full_o) |=> full_o && depth_o == 3'h6) // RULE19
    else $error("Stack depth left its deepest position.");
  empty_hold_a: assert property ((pop_i && !push_i && empty_o) |=>
      empty_o && $stable(top_o)) // RULE20
    else $error("Pop on an empty stack changed the stack.");

endmodule : return_stack

// ### bench/cpu_core_register_set_tb_top.sv
// Self-checking testbench of the core register set: data registers, PC, flags and stack.
`timescale 1ns/1ps
module cpu_core_register_set_tb_top;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [7:0] ds_addr_i = 8'h00;
  logic ds_we_i = 1'b0;
  logic ds_re_i = 1'b0;
  logic [7:0] ds_wdata_i = 8'h00;
  logic [9:0] pc_op_i = 10'h001;
  logic [11:0] pc_target_i = 12'h000;
  logic [7:0] rel_offset_i = 8'h00;
  logic rel_sub_i = 1'b0;
  logic [11:0] vector_i = 12'h000;
  logic bank_we_i = 1'b0;
  logic [1:0] bank_wdata_i = 2'h0;
  logic carry_we_i = 1'b0;
  logic carry_i = 1'b0;
  logic zero_we_i = 1'b0;
  logic [7:0] result_i = 8'h00;
  logic [7:0] ds_rdata_o, sum_o, pointer_one_o, pointer_two_o;
  logic [7:0] short_direct_first_o, short_direct_one_o;
  logic ds_hit_o, carry_o, zero_o;
  logic [11:0] pc_o;
  logic [13:0] fetch_addr_o;
  logic [2:0] ctx_o, stack_depth_o;
  int errors = 0;
  int samples_checked = 0;

  always #5 clk_i = ~clk_i;

  cpu_core_register_set u_dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .ds_addr_i(ds_addr_i),
    .ds_we_i(ds_we_i), .ds_re_i(ds_re_i), .ds_wdata_i(ds_wdata_i), .pc_op_i(pc_op_i),
    .pc_target_i(pc_target_i), .rel_offset_i(rel_offset_i), .rel_sub_i(rel_sub_i),
    .vector_i(vector_i), .bank_we_i(bank_we_i), .bank_wdata_i(bank_wdata_i),
    .carry_we_i(carry_we_i), .carry_i(carry_i), .zero_we_i(zero_we_i), .result_i(result_i),
    .ds_rdata_o(ds_rdata_o), .ds_hit_o(ds_hit_o), .sum_o(sum_o),
    .pointer_one_o(pointer_one_o), .pointer_two_o(pointer_two_o),
    .short_direct_first_o(short_direct_first_o), .short_direct_one_o(short_direct_one_o),
    .pc_o(pc_o), .fetch_addr_o(fetch_addr_o), .carry_o(carry_o), .zero_o(zero_o),
    .ctx_o(ctx_o), .stack_depth_o(stack_depth_o));

  // ****************************************************************
  // Shared drivers and comparison
  // ****************************************************************
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask : check

  task automatic complete_run;
    if (errors == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : complete_run

  // Strobes are held across a call and dropped here, or for ds_we_i by the scenario itself, so none is set twice in a step.
  task automatic idle;
    ds_we_i = 1'b0;
    ds_re_i = 1'b0;
    carry_we_i = 1'b0;
    zero_we_i = 1'b0;
    bank_we_i = 1'b0;
    pc_op_i = core_regs_pkg::PC_HOLD;
    @(negedge clk_i);
  endtask : idle

  task automatic pc_do(input logic [9:0] op, input logic [11:0] arg);
    pc_op_i = op;
    pc_target_i = arg;
    vector_i = arg;
    @(negedge clk_i);
  endtask : pc_do

  task automatic flag_do(input logic c, input logic [7:0] r);
    carry_we_i = 1'b1;
    carry_i = c;
    zero_we_i = 1'b1;
    result_i = r;
    @(negedge clk_i);
    idle();
  endtask : flag_do

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic test_reset;
    check(ctx_o, 16'h0004);
    check({stack_depth_o, pc_o}, 16'h0000);
    check({sum_o, pointer_one_o}, 16'h0000);
  endtask : test_reset

  task automatic test_data;
    logic [7:0] addrs [5];
    logic [7:0] seen [5];
    addrs = '{8'hFF, 8'h80, 8'h81, 8'h82, 8'h83};
    for (int i = 0; i < 5; i++) begin
      ds_we_i = 1'b1;
      ds_addr_i = addrs[i];
      ds_wdata_i = 8'hA0 + 8'(i);
      @(negedge clk_i);
    end
    ds_addr_i = 8'h84;
    ds_wdata_i = 8'h77;
    @(negedge clk_i);
    seen = '{sum_o, pointer_one_o, pointer_two_o, short_direct_first_o, short_direct_one_o};
    ds_we_i = 1'b0;
    for (int i = 0; i < 5; i++) begin
      check(seen[i], 16'h00A0 + 16'(i));
      ds_re_i = 1'b1;
      ds_addr_i = addrs[i];
      @(negedge clk_i);
      check({ds_hit_o, ds_rdata_o}, 16'h01A0 + 16'(i));
    end
    ds_addr_i = 8'h84;
    @(negedge clk_i);
    check({ds_hit_o, ds_rdata_o}, 16'h0000);
    idle();
    check(ds_hit_o, 16'h0000);
  endtask : test_data

  task automatic test_pc;
    pc_do(core_regs_pkg::PC_JUMP, 12'hFFE);
    check(pc_o, 16'h0FFE);
    pc_do(core_regs_pkg::PC_NEXT, 12'h000);
    check(pc_o, 16'h0FFF);
    pc_do(core_regs_pkg::PC_NEXT, 12'h000);
    check(pc_o, 16'h0000);
    rel_offset_i = 8'h05;
    rel_sub_i = 1'b0;
    pc_do(core_regs_pkg::PC_REL, 12'h000);
    check(pc_o, 16'h0005);
    rel_offset_i = 8'h03;
    rel_sub_i = 1'b1;
    pc_do(core_regs_pkg::PC_REL, 12'h000);
    check(pc_o, 16'h0002);
    bank_we_i = 1'b1;
    bank_wdata_i = 2'h3;
    pc_do(core_regs_pkg::PC_RESETV, 12'h0C4);
    idle();
    check(fetch_addr_o, 16'h30C4);
  endtask : test_pc

  task automatic test_stack;
    pc_do(core_regs_pkg::PC_JUMP, 12'h100);
    ds_we_i = 1'b1;
    ds_addr_i = 8'hFF;
    ds_wdata_i = 8'h5A;
    for (int i = 0; i < 7; i++) begin
      pc_do(core_regs_pkg::PC_CALL, 12'h200 + 12'(i));
      ds_we_i = 1'b0;
      check({1'b0, stack_depth_o, pc_o}, (i < 6 ? 16'(i + 1) : 16'h6) * 16'h1000
        + 16'h0200 + 16'(i));
    end
    for (int i = 5; i >= 0; i--) begin
      pc_do(core_regs_pkg::PC_RET, 12'h000);
      check({1'b0, stack_depth_o, pc_o}, 16'(i) * 16'h1000 + 16'h0200 + 16'(i));
    end
    pc_do(core_regs_pkg::PC_IRQ_EXIT_OP, 12'h000);
    check({1'b0, stack_depth_o, pc_o}, 16'h0201);
    idle();
    check(sum_o, 16'h005A);
  endtask : test_stack

  task automatic test_flags;
    flag_do(1'b1, 8'h00);
    check({carry_o, zero_o}, 16'h0003);
    pc_do(core_regs_pkg::PC_IRQ, 12'h040);
    idle();
    check({ctx_o, pc_o}, 16'h2040);
    check({carry_o, zero_o}, 16'h0000);
    flag_do(1'b1, 8'h05);
    check({carry_o, zero_o}, 16'h0002);
    pc_do(core_regs_pkg::PC_URGENT, 12'h080);
    idle();
    check({ctx_o, pc_o}, 16'h4080);
    check({carry_o, zero_o}, 16'h0000);
    pc_do(core_regs_pkg::PC_IRQ_EXIT_OP, 12'h000);
    idle();
    check({ctx_o[1:0], pc_o, carry_o, zero_o}, 16'h8102);
    pc_do(core_regs_pkg::PC_IRQ_EXIT_OP, 12'h000);
    idle();
    check({ctx_o[1:0], pc_o, carry_o, zero_o}, 16'h4807);
    flag_do(1'b0, 8'h00);
    check({carry_o, zero_o}, 16'h0001);
    pc_do(core_regs_pkg::PC_IRQ, 12'h040);
    idle();
    check({carry_o, zero_o}, 16'h0002);
    pc_do(core_regs_pkg::PC_IRQ_EXIT_OP, 12'h000);
    idle();
    check({ctx_o, carry_o, zero_o}, 16'h0005);
  endtask : test_flags

  initial begin
    repeat (4) @(negedge clk_i);
    rst_n_i = 1'b1;
    test_reset();
    test_data();
    test_pc();
    test_stack();
    test_flags();
    complete_run();
  end

  // The whole sequence needs about 60 cycles; 2000 leaves ample margin.
  initial begin
    #20000;
    errors++;
    complete_run();
  end
endmodule : cpu_core_register_set_tb_top
